// *** rtl/weld_cc_pkg.sv ***
// constants and carrier types for the constant-current mode and readout block
package weld_cc_pkg;
  // register offsets on the plain register port
  localparam logic [2:0]  REG_MODE    = 3'h0;
  localparam logic [2:0]  REG_RANGE   = 3'h1;
  localparam logic [2:0]  REG_POUT    = 3'h2;
  localparam logic [2:0]  REG_STATUS  = 3'h3;
  localparam logic [2:0]  REG_LEARNED = 3'h4;
  // reset values
  localparam logic [7:0]  MODE_RST    = 8'h00;
  localparam logic [15:0] RANGE_RST   = 16'h0099;
  localparam logic [7:0]  POUT_RST    = 8'h00;
  // two-digit mode codes, held as bcd
  localparam logic [7:0]  MC_OFF           = 8'h00;
  localparam logic [7:0]  MC_PRI_AUTO_COMP = 8'h10;
  localparam logic [7:0]  MC_PRI_AUTO_MON  = 8'h11;
  localparam logic [7:0]  MC_PRI_PRE_FIRST = 8'h12;
  localparam logic [7:0]  MC_PRI_PRE_LAST  = 8'h19;
  localparam logic [7:0]  MC_SEC_AUTO_COMP = 8'h30;
  localparam logic [7:0]  MC_SEC_AUTO_MON  = 8'h31;
  localparam logic [7:0]  MC_SEC_PRE_COMP  = 8'h32;
  localparam logic [7:0]  MC_SEC_PRE_MON   = 8'h33;
  // range value that selects percent interpretation
  localparam logic [15:0] RANGE_PCT   = 16'h0099;
  // process output codes
  localparam logic [7:0]  POUT_READOUT = 8'h12;
  localparam logic [7:0]  POUT_ALARM   = 8'h13;
  localparam logic [7:0]  POUT_STOP    = 8'h14;
  // alarm valve time, in line cycles
  localparam logic [4:0]  ALARM_LINE_CYCLES = 5'd30;
  // welds sampled during a learning run
  localparam logic [3:0]  LEARN_WELDS = 4'h4;
  // default window is ten percent either side
  localparam logic [15:0] WINDOW_DIV  = 16'h000a;
  localparam int          SCHED_NUM   = 64;

  typedef enum logic [3:0] {
    CC_OFF, PRI_PRE_COMP, PRI_PRE_MON, SEC_PRE_COMP, SEC_PRE_MON,
    PRI_AUTO_COMP, PRI_AUTO_MON, SEC_AUTO_COMP, SEC_AUTO_MON
  } cc_mode_t;

  typedef enum logic [2:0] {
    VIEW_BLANK, VIEW_CURRENT, VIEW_PHASE, VIEW_TAP_UP, VIEW_TAP_DN, VIEW_LO, VIEW_HI
  } view_t;

  typedef enum logic [1:0] {STEP_CURRENT, STEP_LOW, STEP_HIGH} step_t;

  typedef struct packed {
    logic [2:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

  typedef struct packed {
    logic        seq_end;
    logic        weld_made;
    logic [15:0] meas;
    logic [7:0]  phase;
    logic        low_out;
    logic        high_out;
    logic [15:0] sensor_peak;
    logic [15:0] sched_cur;
  } weld_res_t;

  typedef struct packed {
    logic        units;
    logic        tens;
    logic        other;
    logic        right;
    logic        enter;
    logic        sel_pct;
    logic        prog_mode;
    logic [15:0] data;
    logic [5:0]  sched;
  } panel_t;

  typedef struct packed {
    view_t       view;
    logic [15:0] value;
    logic        ka;
    logic        flash;
  } disp_t;
endpackage : weld_cc_pkg

// *** rtl/cc_limit_window.sv ***
// high/low limit window check with the default plus/minus ten percent window
`timescale 1ns/100ps
`default_nettype none
module cc_limit_window (
  input  wire logic [15:0] sched_cur,
  input  wire logic [15:0] lim_lo,
  input  wire logic [15:0] lim_hi,
  input  wire logic [15:0] meas,
  output logic             below,
  output logic             above
);
  import weld_cc_pkg::*;

  logic [15:0] tenth;
  logic [16:0] eff_lo;
  logic [16:0] eff_hi;

  // zero limits fall back to the default window; 17 bits keep the upper edge from wrapping
  always_comb begin
    tenth  = sched_cur / WINDOW_DIV;
    eff_lo = (lim_lo == '0) ? {1'b0, sched_cur - tenth} : {1'b0, lim_lo}; // RULE16
    eff_hi = (lim_hi == '0) ? {1'b0, sched_cur} + {1'b0, tenth} : {1'b0, lim_hi}; // RULE16
    below  = {1'b0, meas} < eff_lo;
    above  = {1'b0, meas} > eff_hi;
  end
endmodule : cc_limit_window
`default_nettype wire

// *** rtl/weld_cc_readout.sv ***
// constant-current mode decode, learning capture, end-of-sequence readout and alarms
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
// Contract
// RULE1: primary preset monitoring codes report current only, no correction, schedule in percent.
// RULE2: auto-range modes base compensation on maximum output learned in setup.
// RULE3: code 30 compensates via secondary coil; range 00.99 percent, else kA.
// RULE4: code 31 monitors secondary auto-range: display only, no compensation, percent.
// RULE5: code 10 compensates via primary transformer; range 00.99 percent, else kA.
// RULE6: primary auto-range monitoring displays current, no compensation, percent schedule.
// RULE7: primary preset modes set amplifier gain from sensor and range value.
// RULE8: percent item selected before initiation shows average current at sequence end.
// RULE9: after readout, units shows phase, tens shows last kA, others clear.
// RULE10: current shows in kA only after a weld in a kA-capable mode.
// RULE11: output too low shows raise-tap indicator; alternate views stay selectable.
// RULE12: output too high shows lower-tap indicator; alternate views stay selectable.
// RULE13: process output 12 always shows current and flashes low/high on failure.
// RULE14: process output 13 also drives alarm valve for 30 line cycles.
// RULE15: process output 14 holds indicator, halts repeat, locks initiation until button.
// RULE16: zero limits mean default window of programmed current plus/minus ten percent.
// RULE17: in program mode right button steps to low then high limit; enter stores.
// RULE18: learning setup samples several welds, records levels, then sets gain.
// RULE19: mode code 00 disables constant current.
// RULE20: codes 32 and 33 select secondary preset compensation and monitoring.
// RULE21: unassigned mode codes act as constant current disabled.
module weld_cc_readout (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire weld_cc_pkg::bus_req_t bus,
  output logic [15:0]                rdata,
  input  wire weld_cc_pkg::weld_res_t res,
  input  wire weld_cc_pkg::panel_t   panel,
  input  wire logic                  line_tick,
  input  wire logic                  learn_start,
  output weld_cc_pkg::disp_t         disp,
  output logic                       tap_up_ind,
  output logic                       lower_tap_indicator,
  output logic                       alarm_valve,
  output logic                       init_lockout,
  output logic                       repeat_halt,
  output logic                       comp_en,
  output logic                       ka_units,
  output logic                       sensor_sec,
  output logic [15:0]                amp_gain,
  output logic                       learn_busy
);
  import weld_cc_pkg::*;

  typedef struct packed {
    logic [7:0]  mode_code;
    logic [15:0] range;
    logic [7:0]  pout;
    logic [15:0] rdata;
    disp_t       disp;
    logic        readout;
    logic [15:0] last_meas;
    logic        tap_up;
    logic        tap_dn;
    logic        alarm;
    logic [4:0]  alarm_cnt;
    logic        lockout;
    logic        halt;
    logic        comp_en;
    logic        ka_units;
    logic        sensor_sec;
    logic [15:0] gain;
    logic        learning;
    logic [3:0]  learn_cnt;
    logic [15:0] learn_max;
    step_t       step;
  } st_t;

  st_t st;
  st_t next_st;

  // per-schedule limit storage, kept outside the state word to avoid a huge register
  logic [15:0] lim_lo_mem [SCHED_NUM];
  logic [15:0] lim_hi_mem [SCHED_NUM];

  cc_mode_t kind;
  logic     pct_mode;
  logic     ka_ok;
  logic     comp;
  logic     cc_on;
  logic     auto_rng;
  logic     sec;
  logic     po_cc;
  logic     below;
  logic     above;
  logic     any_btn;
  logic     entry_on;
  logic     wr_lo;
  logic     wr_hi;

  // mode code decode; anything unlisted falls to constant current off
  always_comb begin
    kind = CC_OFF; // RULE19 RULE21
    if (st.mode_code == MC_PRI_AUTO_COMP) begin
      kind = PRI_AUTO_COMP; // RULE5
    end else if (st.mode_code == MC_PRI_AUTO_MON) begin
      kind = PRI_AUTO_MON; // RULE6
    end else if (st.mode_code == MC_SEC_AUTO_COMP) begin
      kind = SEC_AUTO_COMP; // RULE3
    end else if (st.mode_code == MC_SEC_AUTO_MON) begin
      kind = SEC_AUTO_MON; // RULE4
    end else if (st.mode_code == MC_SEC_PRE_COMP) begin
      kind = SEC_PRE_COMP; // RULE20
    end else if (st.mode_code == MC_SEC_PRE_MON) begin
      kind = SEC_PRE_MON; // RULE20
    end else if (st.mode_code >= MC_PRI_PRE_FIRST && st.mode_code <= MC_PRI_PRE_LAST) begin
      // odd codes monitor, even codes compensate
      kind = st.mode_code[0] ? PRI_PRE_MON : PRI_PRE_COMP; // RULE1
    end
  end

  // per-mode properties; monitoring modes never take kA schedules
  always_comb begin
    pct_mode = (st.range == RANGE_PCT);
    cc_on    = (kind != CC_OFF);
    sec      = (kind == SEC_PRE_COMP) || (kind == SEC_PRE_MON) ||
               (kind == SEC_AUTO_COMP) || (kind == SEC_AUTO_MON);
    auto_rng = (kind == PRI_AUTO_COMP) || (kind == PRI_AUTO_MON) ||
               (kind == SEC_AUTO_COMP) || (kind == SEC_AUTO_MON);
    comp     = (kind == PRI_PRE_COMP) || (kind == SEC_PRE_COMP) ||
               (kind == PRI_AUTO_COMP) || (kind == SEC_AUTO_COMP);
    case (kind)
      PRI_PRE_COMP, SEC_PRE_COMP:   ka_ok = 1'b1;
      PRI_AUTO_COMP, SEC_AUTO_COMP: ka_ok = !pct_mode; // RULE3 RULE5
      default:                      ka_ok = 1'b0; // RULE1 RULE4 RULE6
    endcase
    po_cc    = (st.pout == POUT_READOUT) || (st.pout == POUT_ALARM) || (st.pout == POUT_STOP);
    any_btn  = panel.units || panel.tens || panel.other || panel.right || panel.enter;
    entry_on = panel.prog_mode && panel.sel_pct;
    wr_lo    = entry_on && panel.enter && (st.step == STEP_LOW); // RULE17
    wr_hi    = entry_on && panel.enter && (st.step == STEP_HIGH); // RULE17
  end

  cc_limit_window u_window ( // RULE16
    .sched_cur (res.sched_cur),
    .lim_lo    (lim_lo_mem[panel.sched]),
    .lim_hi    (lim_hi_mem[panel.sched]),
    .meas      (res.meas),
    .below     (below),
    .above     (above)
  );

  // next-state logic; button clears are applied before sequence-end sets so a set wins
  always_comb begin
    next_st       = st;
    next_st.rdata = '0;
    // register writes
    if (bus.wr) begin
      case (bus.addr)
        REG_MODE:  next_st.mode_code = bus.wdata[7:0];
        REG_RANGE: next_st.range     = bus.wdata;
        REG_POUT:  next_st.pout      = bus.wdata[7:0];
        default:   ;
      endcase
    end
    // register reads, unmapped offsets read zero
    if (bus.rd) begin
      case (bus.addr)
        REG_MODE:    next_st.rdata = {8'h00, st.mode_code};
        REG_RANGE:   next_st.rdata = st.range;
        REG_POUT:    next_st.rdata = {8'h00, st.pout};
        REG_STATUS:  next_st.rdata = {5'h00, st.halt, st.lockout, st.alarm, st.learning,
                                      ka_ok, comp, sec, kind};
        REG_LEARNED: next_st.rdata = st.learn_max;
        default:     next_st.rdata = '0;
      endcase
    end
    next_st.comp_en    = comp; // RULE1 RULE4 RULE6 RULE19
    next_st.ka_units   = ka_ok;
    next_st.sensor_sec = sec;
    // learned maximum drives gain in auto range, the range value in preset range
    next_st.gain = auto_rng ? st.learn_max : st.range; // RULE2 RULE7
    // learning run: sample the sensor peak over a fixed number of welds
    if (learn_start && auto_rng && !st.learning) begin
      next_st.learning  = 1'b1; // RULE18
      next_st.learn_cnt = '0;
      next_st.learn_max = '0;
    end else if (st.learning && res.seq_end) begin
      if (res.sensor_peak > st.learn_max) begin
        next_st.learn_max = res.sensor_peak; // RULE18
      end
      next_st.learn_cnt = st.learn_cnt + 4'h1;
      if (st.learn_cnt == LEARN_WELDS - 4'h1) begin
        next_st.learning = 1'b0; // RULE18
      end
    end
    // alarm valve counts line cycles, not clock cycles
    if (st.alarm && line_tick) begin
      next_st.alarm_cnt = st.alarm_cnt + 5'd1;
      if (st.alarm_cnt == ALARM_LINE_CYCLES - 5'd1) begin
        next_st.alarm = 1'b0; // RULE14
      end
    end
    // any front panel button releases the stop lockout
    if (any_btn) begin
      next_st.lockout = 1'b0; // RULE15
      next_st.halt    = 1'b0; // RULE15
    end
    // data buttons pick alternate views while a readout stands
    if (st.readout) begin
      if (panel.units) begin
        next_st.disp.view  = VIEW_PHASE; // RULE9 RULE11 RULE12
        next_st.disp.value = {8'h00, res.phase};
        next_st.disp.flash = 1'b0;
      end else if (panel.tens) begin
        next_st.disp.view  = VIEW_CURRENT; // RULE9
        next_st.disp.value = st.last_meas;
        next_st.disp.flash = 1'b0;
      end else if (any_btn) begin
        next_st.disp.view  = VIEW_BLANK; // RULE9
        next_st.disp.flash = 1'b0;
        next_st.readout    = 1'b0;
      end
    end
    // end of sequence readout; a learning run shows nothing
    if (res.seq_end && !st.learning) begin
      if (cc_on && (po_cc || panel.sel_pct)) begin
        next_st.readout    = 1'b1; // RULE8 RULE13
        next_st.last_meas  = res.meas;
        next_st.disp.value = res.meas;
        next_st.disp.ka    = res.weld_made && ka_ok; // RULE10
        next_st.disp.view  = VIEW_CURRENT;
        next_st.disp.flash = 1'b0;
        if (po_cc && (below || above)) begin
          next_st.disp.view  = below ? VIEW_LO : VIEW_HI; // RULE13
          // the stop code holds the indicator steady instead of flashing
          next_st.disp.flash = (st.pout != POUT_STOP); // RULE13 RULE15
          if (st.pout == POUT_ALARM) begin
            next_st.alarm     = 1'b1; // RULE14
            next_st.alarm_cnt = '0;
          end
          if (st.pout == POUT_STOP) begin
            next_st.lockout = 1'b1; // RULE15
            next_st.halt    = 1'b1; // RULE15
          end
        end else if (!po_cc && res.low_out) begin
          next_st.disp.view = VIEW_TAP_UP; // RULE11
        end else if (!po_cc && res.high_out) begin
          next_st.disp.view = VIEW_TAP_DN; // RULE12
        end
      end else begin
        next_st.readout   = 1'b0;
        next_st.disp.view = VIEW_BLANK;
        next_st.disp.ka   = 1'b0; // RULE10
      end
    end
    next_st.tap_up = (next_st.disp.view == VIEW_TAP_UP); // RULE11
    next_st.tap_dn = (next_st.disp.view == VIEW_TAP_DN); // RULE12
    // limit entry stepping under the percent-current item
    if (!entry_on) begin
      next_st.step = STEP_CURRENT;
    end else if (panel.right) begin
      case (st.step)
        STEP_CURRENT: next_st.step = STEP_LOW; // RULE17
        STEP_LOW:     next_st.step = STEP_HIGH; // RULE17
        default:      next_st.step = STEP_CURRENT;
      endcase
    end
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st           <= '0;
      st.mode_code <= MODE_RST;
      st.range     <= RANGE_RST;
      st.pout      <= POUT_RST;
      st.disp.view <= VIEW_BLANK;
      st.step      <= STEP_CURRENT;
    end else begin
      st <= next_st;
    end
  end

  // limit memory; zero at reset so the default window applies until programmed
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < SCHED_NUM; i++) begin
        lim_lo_mem[i] <= '0;
        lim_hi_mem[i] <= '0;
      end
    end else begin
      if (wr_lo) begin
        lim_lo_mem[panel.sched] <= panel.data; // RULE17
      end
      if (wr_hi) begin
        lim_hi_mem[panel.sched] <= panel.data; // RULE17
      end
    end
  end

  // outputs come straight from the state register
  assign rdata               = st.rdata;
  assign disp                = st.disp;
  assign tap_up_ind          = st.tap_up;
  assign lower_tap_indicator = st.tap_dn;
  assign alarm_valve         = st.alarm;
  assign init_lockout        = st.lockout;
  assign repeat_halt         = st.halt;
  assign comp_en             = st.comp_en;
  assign ka_units            = st.ka_units;
  assign sensor_sec          = st.sensor_sec;
  assign amp_gain            = st.gain;
  assign learn_busy          = st.learning;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_mode_off_idle: assert property ((st.mode_code == MC_OFF) |=> !comp_en && !ka_units) // RULE19
    else $error("mode 00 left compensation on");
  a_unknown_mode_off: assert property ((st.mode_code == 8'h77) |=> !comp_en) // RULE21
    else $error("unassigned mode code compensates");
  a_pri_pre_monitor: assert property ((st.mode_code == 8'h17) |=> !comp_en && !ka_units) // RULE1
    else $error("primary preset monitor compensates");
  a_sec_auto_mon: assert property ((st.mode_code == MC_SEC_AUTO_MON) |=> !comp_en && sensor_sec) // RULE4
    else $error("secondary auto monitor wrong");
  a_pri_auto_units: assert property ((st.mode_code == MC_PRI_AUTO_COMP && st.range != RANGE_PCT)
    |=> comp_en && ka_units && !sensor_sec) // RULE5
    else $error("primary auto kA mode wrong");
  a_sec_auto_pct: assert property ((st.mode_code == MC_SEC_AUTO_COMP && st.range == RANGE_PCT)
    |=> comp_en && !ka_units) // RULE3
    else $error("secondary auto percent mode wrong");
  a_sec_pre_units: assert property ((st.mode_code == MC_SEC_PRE_COMP) |=> ka_units && sensor_sec) // RULE20
    else $error("secondary preset compensation wrong");
  a_preset_gain: assert property ((kind == PRI_PRE_COMP) |=> amp_gain == $past(st.range)) // RULE7
    else $error("preset gain not from range");
  a_alarm_end: assert property ((alarm_valve && line_tick && st.alarm_cnt == 5'd29) |=> !alarm_valve) // RULE14
    else $error("alarm valve overran 30 line cycles");
  a_alarm_hold: assert property ($rose(alarm_valve) |-> st.alarm_cnt == 5'd0 ##1 alarm_valve) // RULE14
    else $error("alarm valve dropped early");
  a_lockout_clear: assert property ((init_lockout && panel.other && !res.seq_end) |=> !init_lockout) // RULE15
    else $error("button did not clear lockout");
  a_units_phase: assert property ((st.readout && panel.units && !res.seq_end)
    |=> disp.view == VIEW_PHASE && disp.value[7:0] == $past(res.phase)) // RULE9
    else $error("units button did not show phase");
  a_ka_needs_weld: assert property ((res.seq_end && !res.weld_made) |=> !disp.ka) // RULE10
    else $error("kA shown without a weld");
  a_learn_ends: assert property ($rose(learn_busy) |-> learn_busy [*2]) // RULE18
    else $error("learning run ended at once");
endmodule : weld_cc_readout
`default_nettype wire

// *** bench/weld_partner.sv ***
// far-side model: weld sequence end and sensor results as the block sees them
`timescale 1ns/100ps
`default_nettype none
module weld_partner (
  input  wire logic                   sys_clk,
  input  wire logic                   fire,
  input  wire weld_cc_pkg::weld_res_t cfg,
  output weld_cc_pkg::weld_res_t      res
);
  import weld_cc_pkg::*;
  initial res = '0;
  // results are valid only beside seq_end; between welds meas, weld_made, low_out, high_out and sensor_peak toggle every cycle
  // so that a block reading them late never sees a stale but plausible value
  always @(posedge sys_clk) begin
    if (fire) begin
      res <= cfg;
    end else begin
      res.seq_end     <= 1'b0;
      res.meas        <= ~res.meas;
      res.weld_made   <= ~res.weld_made;
      res.low_out     <= ~res.low_out;
      res.high_out    <= ~res.high_out;
      res.sensor_peak <= ~res.sensor_peak;
    end
  end
endmodule : weld_partner
`default_nettype wire

// *** bench/tb_top.sv ***
// self-checking bench for the constant-current mode and readout block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb_top;
  import weld_cc_pkg::*;
  logic        sys_clk, rst, line_tick, learn_start, fire;
  bus_req_t    bus;
  logic [15:0] rdata, amp_gain, v;
  weld_res_t   res, cfg;
  panel_t      panel;
  disp_t       disp;
  logic        tap_up, tap_dn, alarm_valve, init_lockout, repeat_halt;
  logic        comp_en, ka_units, sensor_sec, learn_busy;
  int          fails, comparisons, cycles;

  weld_cc_readout i_dut (.sys_clk(sys_clk), .rst(rst), .bus(bus), .rdata(rdata), .res(res),
    .panel(panel), .line_tick(line_tick), .learn_start(learn_start), .disp(disp),
    .tap_up_ind(tap_up), .lower_tap_indicator(tap_dn), .alarm_valve(alarm_valve),
    .init_lockout(init_lockout), .repeat_halt(repeat_halt), .comp_en(comp_en),
    .ka_units(ka_units), .sensor_sec(sensor_sec), .amp_gain(amp_gain), .learn_busy(learn_busy));
  weld_partner i_far (.sys_clk(sys_clk), .fire(fire), .cfg(cfg), .res(res));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // hang guard, well above the few hundred cycles the tests need
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge sys_clk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk) bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [15:0] q);
    @(posedge sys_clk) bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk) bus.rd <= 1'b0;
    #1 q = rdata;
  endtask : rd
  task automatic setup(input logic [7:0] m, input logic [15:0] r, input logic [7:0] p);
    wr(REG_MODE, {8'h00, m});
    wr(REG_RANGE, r);
    wr(REG_POUT, {8'h00, p});
    tick(2);
  endtask : setup
  // one weld: the far side raises seq_end for one cycle with these results
  task automatic weld(input logic [15:0] m, input logic lo, input logic hi);
    @(posedge sys_clk) begin
      cfg.meas <= m;
      cfg.low_out <= lo;
      cfg.high_out <= hi;
      fire <= 1'b1;
    end
    @(posedge sys_clk) fire <= 1'b0;
    tick(1);
  endtask : weld
  // button pulse: 0 units, 1 tens, 2 other, 3 right, 4 enter
  task automatic press(input int b, input logic [15:0] d);
    @(posedge sys_clk) begin
      panel.data <= d;
      case (b)
        0: panel.units <= 1'b1;
        1: panel.tens <= 1'b1;
        2: panel.other <= 1'b1;
        3: panel.right <= 1'b1;
        default: panel.enter <= 1'b1;
      endcase
    end
    @(posedge sys_clk) {panel.units, panel.tens, panel.other, panel.right, panel.enter} <= '0;
    #1;
  endtask : press
  task automatic pulse_tick();
    @(posedge sys_clk) line_tick <= 1'b1;
    @(posedge sys_clk) line_tick <= 1'b0;
    #1;
  endtask : pulse_tick

  task automatic t_reset();
    rd(REG_MODE, v);    `CHK("mode", 16'h0000, v)
    rd(REG_RANGE, v);   `CHK("range", 16'h0099, v)
    rd(REG_POUT, v);    `CHK("pout", 16'h0000, v)
    rd(3'h5, v);        `CHK("unmapped", 16'h0000, v)
    `CHK("gain", 16'h0099, amp_gain)
    `CHK("comp", 1'b0, comp_en)
    $display("test reset done");
  endtask : t_reset
  task automatic t_modes();
    logic [7:0] code [10] = '{8'h00, 8'h10, 8'h11, 8'h12, 8'h17, 8'h30, 8'h31, 8'h32, 8'h33, 8'h77};
    logic [3:0] kind [10] = '{4'h0, 4'h5, 4'h6, 4'h1, 4'h2, 4'h7, 4'h8, 4'h3, 4'h4, 4'h0};
    logic [9:0] comp = 10'b0101010100;
    logic [9:0] sec  = 10'b0000011110;
    for (int i = 0; i < 10; i++) begin
      wr(REG_MODE, {8'h00, code[i]});
      tick(2);
      `CHK("comp_en", comp[9-i], comp_en)
      `CHK("sensor_sec", sec[9-i], sensor_sec)
      rd(REG_STATUS, v);  `CHK("kind", kind[i], v[3:0])
    end
    setup(8'h10, 16'h1500, 8'h00);  `CHK("ka 10", 1'b1, ka_units)
    setup(8'h30, 16'h1500, 8'h00);  `CHK("ka 30", 1'b1, ka_units)
    setup(8'h30, 16'h0099, 8'h00);  `CHK("pct 30", 1'b0, ka_units)
    $display("test modes done");
  endtask : t_modes
  task automatic t_views();
    setup(8'h33, 16'h0099, 8'h00);
    panel.sel_pct <= 1'b1;
    weld(16'h1234, 1'b0, 1'b0);
    `CHK("view", VIEW_CURRENT, disp.view)
    `CHK("value", 16'h1234, disp.value)
    `CHK("ka", 1'b0, disp.ka)
    press(0, 16'h0000); `CHK("phase", VIEW_PHASE, disp.view)
    `CHK("phase val", 16'h0047, disp.value)
    press(1, 16'h0000); `CHK("tens", 16'h1234, disp.value)
    press(2, 16'h0000); `CHK("clear", VIEW_BLANK, disp.view)
    press(0, 16'h0000); `CHK("no readout", VIEW_BLANK, disp.view)
    weld(16'h1234, 1'b0, 1'b0); `CHK("again", VIEW_CURRENT, disp.view)
    panel.sel_pct <= 1'b0;
    weld(16'h1234, 1'b0, 1'b0); `CHK("unselected", VIEW_BLANK, disp.view)
    panel.sel_pct <= 1'b1;
    setup(8'h30, 16'h1500, 8'h00);
    weld(16'h0800, 1'b0, 1'b0); `CHK("ka 30", 1'b1, disp.ka)
    cfg.weld_made <= 1'b0;
    weld(16'h0800, 1'b0, 1'b0); `CHK("no weld", 1'b0, disp.ka)
    cfg.weld_made <= 1'b1;
    setup(8'h31, 16'h1500, 8'h00);
    weld(16'h0800, 1'b0, 1'b0); `CHK("ka 31", 1'b0, disp.ka)
    setup(8'h10, 16'h0099, 8'h00);
    weld(16'h0100, 1'b1, 1'b0); `CHK("up", VIEW_TAP_UP, disp.view)
    `CHK("up ind", 1'b1, tap_up)
    press(0, 16'h0000); `CHK("up phase", VIEW_PHASE, disp.view)
    weld(16'h0100, 1'b0, 1'b1); `CHK("dn", VIEW_TAP_DN, disp.view)
    `CHK("dn ind", 1'b1, tap_dn)
    press(1, 16'h0000); `CHK("dn cur", 16'h0100, disp.value)
    `CHK("dn view", VIEW_CURRENT, disp.view)
    panel.sel_pct <= 1'b0;
    $display("test views done");
  endtask : t_views
  task automatic t_window();
    setup(8'h12, 16'h0099, 8'h12);
    weld(16'h0050, 1'b0, 1'b0); `CHK("lo", VIEW_LO, disp.view)
    `CHK("flash", 1'b1, disp.flash)
    weld(16'h005a, 1'b0, 1'b0); `CHK("edge lo", VIEW_CURRENT, disp.view)
    weld(16'h006e, 1'b0, 1'b0); `CHK("edge hi", VIEW_CURRENT, disp.view)
    weld(16'h006f, 1'b0, 1'b0); `CHK("hi", VIEW_HI, disp.view)
    wr(REG_POUT, 16'h0013);
    weld(16'h0050, 1'b0, 1'b0); `CHK("alarm on", 1'b1, alarm_valve)
    repeat (29) pulse_tick();
    `CHK("alarm 29", 1'b1, alarm_valve)
    pulse_tick();  `CHK("alarm off", 1'b0, alarm_valve)
    wr(REG_POUT, 16'h0014);
    weld(16'h006f, 1'b0, 1'b0); `CHK("stop hi", VIEW_HI, disp.view)
    `CHK("steady", 1'b0, disp.flash)
    `CHK("lockout", 1'b1, init_lockout)
    `CHK("halt", 1'b1, repeat_halt)
    press(2, 16'h0000); `CHK("unlock", 1'b0, init_lockout)
    `CHK("unhalt", 1'b0, repeat_halt)
    weld(16'h0060, 1'b0, 1'b0); `CHK("in window", VIEW_CURRENT, disp.view)
    setup(8'h00, 16'h0099, 8'h12);
    weld(16'h0050, 1'b0, 1'b0); `CHK("cc off", VIEW_BLANK, disp.view)
    $display("test window done");
  endtask : t_window
  task automatic t_limits();
    setup(8'h12, 16'h0099, 8'h12);
    panel.sched <= 6'h05;
    panel.prog_mode <= 1'b1;
    panel.sel_pct <= 1'b1;
    press(3, 16'h0000);
    press(4, 16'h0040);
    press(3, 16'h0000);
    press(4, 16'h0060);
    press(3, 16'h0000);
    panel.prog_mode <= 1'b0;
    weld(16'h0062, 1'b0, 1'b0); `CHK("user hi", VIEW_HI, disp.view)
    weld(16'h003f, 1'b0, 1'b0); `CHK("user lo", VIEW_LO, disp.view)
    weld(16'h0050, 1'b0, 1'b0); `CHK("user in", VIEW_CURRENT, disp.view)
    panel.sel_pct <= 1'b0;
    $display("test limits done");
  endtask : t_limits
  task automatic t_learn();
    logic [15:0] peak [4] = '{16'h0300, 16'h0500, 16'h0200, 16'h0400};
    setup(8'h12, 16'h1000, 8'h00);  `CHK("preset gain", 16'h1000, amp_gain)
    setup(8'h10, 16'h0099, 8'h00);
    @(posedge sys_clk) learn_start <= 1'b1;
    @(posedge sys_clk) learn_start <= 1'b0;
    #1 `CHK("busy", 1'b1, learn_busy)
    for (int i = 0; i < 4; i++) begin
      cfg.sensor_peak <= peak[i];
      weld(16'h0100, 1'b0, 1'b0);
      `CHK("busy run", (i < 3), learn_busy)
    end
    rd(REG_LEARNED, v);  `CHK("learned", 16'h0500, v)
    tick(2);  `CHK("auto gain", 16'h0500, amp_gain)
    $display("test learn done");
  endtask : t_learn

  initial begin
    rst = 1'b1;
    bus = '0;
    panel = '0;
    cfg = '0;
    cfg.seq_end = 1'b1;
    cfg.weld_made = 1'b1;
    cfg.phase = 8'h47;
    cfg.sched_cur = 16'h0064;
    line_tick = 1'b0;
    learn_start = 1'b0;
    fire = 1'b0;
    fails = 0;
    comparisons = 0;
    cycles = 0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    tick(1);
    t_reset();
    t_modes();
    t_views();
    t_window();
    t_limits();
    t_learn();
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
